// [src/fwsr_host.sv]
`timescale 1ns/100ps
// Functional notes
// - Host drives the programmed address while reading polling status.
// - Host reads erase status at an address in a selected sector.
// - Bit 7 may turn to data early; host trusts only a later read.
// - Host reads full byte twice; unchanged toggle means done.
// - Toggling with timeout flag high: recheck, still toggling means reset.
// - Host restarts toggle check from the first read after leaving.
// - Host re-reads polling bit even after timeout flag is seen.
// - After timeout failure host writes reset F0; device returns to read.
module fwsr_host
    import fwsr_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                start,
    input  wire logic                mode_poll,
    input  wire logic [ADDR_W-1:0]   status_addr,
    input  wire logic [DATA_W-1:0]   expect_data,
    input  wire logic                abort,
    input  wire logic [DATA_W-1:0]   dq_in,
    input  wire logic                ready_busy_n_out,
    output logic      [ADDR_W-1:0]   addr,
    output logic      [DATA_W-1:0]   dq_out,
    output logic                     dq_oe,
    output logic                     chip_sel_n,
    output logic                     out_strobe_n,
    output logic                     wr_strobe_n,
    output logic                     busy,
    output logic                     done,
    output logic                     fail,
    output logic      [DATA_W-1:0]   last_data,
    output logic                     device_ready
);
    fwsr_state_t        state;
    fwsr_step_t         step;
    fwsr_mode_t         mode;
    logic [3:0]         count;
    logic               is_write;
    logic [ADDR_W-1:0]  target;
    logic [DATA_W-1:0]  expect_q;
    logic [DATA_W-1:0]  dq_meta;
    logic [DATA_W-1:0]  dq_sync;
    logic               rb_meta;
    logic               rb_sync;
    logic [DATA_W-1:0]  first_byte;
    logic [DATA_W-1:0]  sampled;

    // Pins from the device are asynchronous to clk
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dq_meta <= 8'h00;
            dq_sync <= 8'h00;
            rb_meta <= 1'b1;
            rb_sync <= 1'b1;
        end else begin
            dq_meta <= dq_in;
            dq_sync <= dq_meta;
            rb_meta <= ready_busy_n_out;
            rb_sync <= rb_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            device_ready <= 1'b1;
        end else begin
            device_ready <= rb_sync;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state      <= FWSR_IDLE;
            step       <= FWSR_STEP_FIRST;
            mode       <= FWSR_MODE_TOGGLE;
            count      <= 4'h0;
            is_write   <= 1'b0;
            target     <= ANY_ADDR;
            expect_q   <= 8'h00;
            first_byte <= 8'h00;
            sampled    <= 8'h00;
            busy       <= 1'b0;
            done       <= 1'b0;
            fail       <= 1'b0;
            last_data  <= 8'h00;
        end else begin
            done <= 1'b0;
            fail <= 1'b0;
            case (state)
                FWSR_IDLE: begin
                    // Start only after the command has been fully written
                    if (start) begin
                        mode     <= mode_poll ? FWSR_MODE_POLL : FWSR_MODE_TOGGLE;
                        target   <= status_addr;
                        expect_q <= expect_data;
                        step     <= FWSR_STEP_FIRST;
                        is_write <= 1'b0;
                        busy     <= 1'b1;
                        count    <= SETUP_CNT;
                        state    <= FWSR_SETUP;
                    end
                end
                FWSR_SETUP: begin
                    if (count > 4'h1) begin
                        count <= count - 4'h1;
                    end else begin
                        count <= STROBE_CNT;
                        state <= FWSR_STROBE;
                    end
                end
                FWSR_STROBE: begin
                    if (count > 4'h1) begin
                        count <= count - 4'h1;
                    end else begin
                        // Sample late in the strobe, data is two flops behind
                        sampled <= dq_sync;
                        count   <= SETUP_CNT;
                        state   <= FWSR_HOLD;
                    end
                end
                FWSR_HOLD: begin
                    if (count > 4'h1) begin
                        count <= count - 4'h1;
                    end else if (is_write) begin
                        fail  <= 1'b1;
                        busy  <= 1'b0;
                        state <= FWSR_IDLE;
                    end else begin
                        state <= FWSR_EVAL;
                    end
                end
                FWSR_EVAL: begin
                    last_data <= sampled;
                    count     <= SETUP_CNT;
                    state     <= FWSR_SETUP;
                    if (abort) begin
                        // Leaving the loop; next start begins at the first read
                        busy  <= 1'b0;
                        state <= FWSR_IDLE;
                    end else if (mode == FWSR_MODE_POLL) begin
                        if (sampled[POLL_POS] == expect_q[POLL_POS]) begin
                            // Bit 7 may lead the rest; read once more for data
                            if (step == FWSR_STEP_SECOND) begin
                                state <= FWSR_DONE;
                            end else begin
                                step <= FWSR_STEP_SECOND;
                            end
                        end else if (sampled[TIMEOUT_POS]) begin
                            if (step == FWSR_STEP_RECHK) begin
                                step     <= FWSR_STEP_RESET;
                                is_write <= 1'b1;
                                target   <= ANY_ADDR;
                            end else begin
                                step <= FWSR_STEP_RECHK;
                            end
                        end else begin
                            // A miss breaks the run of matching reads
                            step <= FWSR_STEP_FIRST;
                        end
                    end else begin
                        case (step)
                            FWSR_STEP_FIRST: begin
                                first_byte <= sampled;
                                step       <= FWSR_STEP_SECOND;
                            end
                            FWSR_STEP_SECOND, FWSR_STEP_RECHK: begin
                                first_byte <= sampled;
                                if (sampled[TOGGLE_ONE_POS] == first_byte[TOGGLE_ONE_POS]) begin
                                    state <= FWSR_DONE;
                                end else if (step == FWSR_STEP_RECHK) begin
                                    step     <= FWSR_STEP_RESET;
                                    is_write <= 1'b1;
                                    target   <= ANY_ADDR;
                                end else if (sampled[TIMEOUT_POS]) begin
                                    step <= FWSR_STEP_RECHK;
                                end
                            end
                            default: begin
                                state <= FWSR_IDLE;
                            end
                        endcase
                    end
                end
                FWSR_DONE: begin
                    done  <= 1'b1;
                    busy  <= 1'b0;
                    state <= FWSR_IDLE;
                end
                default: begin
                    busy  <= 1'b0;
                    state <= FWSR_IDLE;
                end
            endcase
        end
    end

    // Pin drive registered so strobes never glitch
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr         <= ANY_ADDR;
            dq_out       <= 8'h00;
            dq_oe        <= 1'b0;
            chip_sel_n   <= 1'b1;
            out_strobe_n <= 1'b1;
            wr_strobe_n  <= 1'b1;
        end else begin
            addr         <= target;
            dq_out       <= RESET_CMD;
            dq_oe        <= is_write && (state != FWSR_IDLE);
            chip_sel_n   <= !(state == FWSR_SETUP || state == FWSR_STROBE
                              || state == FWSR_HOLD);
            out_strobe_n <= !(state == FWSR_STROBE && !is_write);
            wr_strobe_n  <= !(state == FWSR_STROBE && is_write);
        end
    end
endmodule // fwsr_host

// [inc/fwsr_pkg.sv]
package fwsr_pkg;
    localparam int          CLK_MHZ        = 40;
    localparam int          ADDR_W         = 22;
    localparam int          DATA_W         = 8;
    // Bus strobe timing, given in ns and rounded up to cycles
    localparam int          SETUP_NS       = 25;
    localparam int          STROBE_NS      = 100;
    localparam int          SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          STROBE_CYC     = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  STROBE_CNT     = 4'(STROBE_CYC);
    localparam logic [3:0]  SETUP_CNT      = 4'(SETUP_CYC);
    // Field positions in the status byte
    localparam int          POLL_POS       = 7;
    localparam int          TOGGLE_ONE_POS = 6;
    localparam int          TIMEOUT_POS    = 5;
    localparam int          TOGGLE_TWO_POS = 2;
    localparam logic [7:0]  RESET_CMD      = 8'hF0;
    localparam logic [ADDR_W-1:0] ANY_ADDR = 22'h000000;

    typedef enum logic [1:0] {
        FWSR_MODE_TOGGLE = 2'b00,
        FWSR_MODE_POLL   = 2'b01
    } fwsr_mode_t;

    typedef enum logic [3:0] {
        FWSR_IDLE    = 4'b0000,
        FWSR_SETUP   = 4'b0001,
        FWSR_STROBE  = 4'b0010,
        FWSR_HOLD    = 4'b0011,
        FWSR_EVAL    = 4'b0100,
        FWSR_DONE    = 4'b0101,
        FWSR_FAIL    = 4'b0110
    } fwsr_state_t;

    typedef enum logic [1:0] {
        FWSR_STEP_FIRST  = 2'b00,
        FWSR_STEP_SECOND = 2'b01,
        FWSR_STEP_RECHK  = 2'b10,
        FWSR_STEP_RESET  = 2'b11
    } fwsr_step_t;
endpackage

// [bench/fwsr_host_sva.sv]
`timescale 1ns/100ps
module fwsr_host_sva
    import fwsr_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              start,
    input wire logic              mode_poll,
    input wire logic [ADDR_W-1:0] status_addr,
    input wire logic [DATA_W-1:0] expect_data,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic              dq_oe,
    input wire logic              chip_sel_n,
    input wire logic              out_strobe_n,
    input wire logic              wr_strobe_n,
    input wire logic              busy,
    input wire logic              done,
    input wire logic              fail,
    input wire logic [DATA_W-1:0] last_data
);
    logic [1:0] rd_cnt;
    logic       os_q;
    logic       poll_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Reads since start, saturating so a long check cannot wrap
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_cnt <= 2'h0;
            os_q   <= 1'h1;
            poll_q <= 1'h0;
        end else begin
            os_q <= out_strobe_n;
            if (start && !busy) begin
                rd_cnt <= 2'h0;
                poll_q <= mode_poll;
            end else if (out_strobe_n && !os_q && rd_cnt != 2'h3) begin
                rd_cnt <= rd_cnt + 2'h1;
            end
        end
    end
    a_read_addr: assert property (!out_strobe_n |-> !chip_sel_n && addr == status_addr)
        else $error("status read off the status address");
    a_read_undriven: assert property (!out_strobe_n |-> !dq_oe && wr_strobe_n)
        else $error("host drives the bus during a read");
    a_strobe_len: assert property ($fell(out_strobe_n) |-> !out_strobe_n[*4] ##1 out_strobe_n)
        else $error("read strobe width wrong");
    a_two_reads: assert property (done |-> rd_cnt >= 2'h2)
        else $error("done after fewer than two reads");
    a_poll_match: assert property (done && poll_q |-> last_data[POLL_POS] == expect_data[POLL_POS])
        else $error("poll done on a wrong bit");
    a_fail_flag: assert property (fail |-> last_data[TIMEOUT_POS])
        else $error("fail without timeout flag");
    a_reset_data: assert property (!wr_strobe_n |-> dq_oe && dq_out == RESET_CMD)
        else $error("write is not the reset command");
    a_write_fail: assert property ($rose(wr_strobe_n) |-> fail)
        else $error("reset write without fail pulse");
    a_start_busy: assert property (start && !busy |=> busy)
        else $error("start not taken");
    cover property (done && poll_q);
    cover property (done && !poll_q);
    cover property (fail);
endmodule // fwsr_host_sva
bind fwsr_host fwsr_host_sva u_sva (
    .clk(clk), .rst_b(rst_b), .start(start), .mode_poll(mode_poll),
    .status_addr(status_addr), .expect_data(expect_data), .addr(addr), .dq_out(dq_out),
    .dq_oe(dq_oe), .chip_sel_n(chip_sel_n), .out_strobe_n(out_strobe_n),
    .wr_strobe_n(wr_strobe_n), .busy(busy), .done(done), .fail(fail), .last_data(last_data)
);

// [bench/fwsr_flash_model.sv]
`timescale 1ns/100ps
module fwsr_flash_model
    import fwsr_pkg::*;
(
    input  wire logic              load,
    input  wire logic [1:0]        kind,
    input  wire logic [7:0]        n_reads,
    input  wire logic              to_flag,
    input  wire logic [DATA_W-1:0] data,
    input  wire logic [DATA_W-1:0] dq_wr,
    input  wire logic              dq_oe,
    input  wire logic              chip_sel_n,
    input  wire logic              out_strobe_n,
    input  wire logic              wr_strobe_n,
    output logic      [DATA_W-1:0] dq_rd,
    output logic                   ready_busy_n_out
);
    logic [7:0]        left = 8'h00;
    logic              tog = 1'h0;
    logic              to = 1'h0;
    logic [1:0]        op = 2'h0;
    logic [DATA_W-1:0] arr = 8'h00;
    logic [DATA_W-1:0] held = 8'h00;
    logic [DATA_W-1:0] stat;
    wire               rd = !chip_sel_n && !out_strobe_n;
    always @(posedge load) begin
        op = kind;
        left = n_reads;
        to = to_flag;
        arr = data;
        tog = 1'h0;
    end
    always_comb begin
        if (left == 8'h00) stat = arr;
        else if (op == 2'h2) stat = {1'h0, tog, to, 2'h0, tog, 2'h0};
        else stat = {~arr[7], tog, to, 5'h00};
    end
    // Timeout freezes progress, so only the reset write ends it
    always @(negedge rd) begin
        held = stat;
        if (left != 8'h00) begin
            tog = ~tog;
            // Status span counted in reads, not time
            if (!to) left = left - 8'h01;
        end
    end
    always @* begin
        if (!wr_strobe_n && dq_oe && dq_wr == RESET_CMD) begin
            left = 8'h00;
            to = 1'h0;
        end
    end
    // Released bus shows the inverse, not a stale byte
    assign dq_rd = rd ? stat : ~held;
    assign ready_busy_n_out = (left == 8'h00);
endmodule // fwsr_flash_model

// [bench/fwsr_host_bench.sv]
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module fwsr_host_bench
    import fwsr_pkg::*;
;
    logic              clk = 1'h0;
    logic              rst_b = 1'h0;
    logic              start = 1'h0;
    logic              mode_poll = 1'h0;
    logic              abort = 1'h0;
    logic              load = 1'h0;
    logic              to_flag = 1'h0;
    logic [1:0]        kind = 2'h0;
    logic [7:0]        n_reads = 8'h00;
    logic [ADDR_W-1:0] status_addr = 22'h000000;
    logic [DATA_W-1:0] expect_data = 8'h00;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out, dq_rd, last_data;
    logic              dq_oe, chip_sel_n, out_strobe_n, wr_strobe_n, rbn;
    logic              busy, done, fail, device_ready;
    logic [31:0]       seed = 32'h00007C97;
    logic [16:0]       notes[$];
    logic [16:0]       nt;
    int                n_mismatch = 0;
    int                n_checks = 0;
    wire  [DATA_W-1:0] bus = dq_oe ? dq_out : dq_rd;
    fwsr_host dut (
        .clk(clk), .rst_b(rst_b), .start(start), .mode_poll(mode_poll),
        .status_addr(status_addr), .expect_data(expect_data), .abort(abort),
        .dq_in(bus), .ready_busy_n_out(rbn), .addr(addr), .dq_out(dq_out),
        .dq_oe(dq_oe), .chip_sel_n(chip_sel_n), .out_strobe_n(out_strobe_n),
        .wr_strobe_n(wr_strobe_n), .busy(busy), .done(done), .fail(fail),
        .last_data(last_data), .device_ready(device_ready));
    fwsr_flash_model model (
        .load(load), .kind(kind), .n_reads(n_reads), .to_flag(to_flag), .data(expect_data),
        .dq_wr(dq_out), .dq_oe(dq_oe), .chip_sel_n(chip_sel_n), .out_strobe_n(out_strobe_n),
        .wr_strobe_n(wr_strobe_n), .dq_rd(dq_rd), .ready_busy_n_out(rbn));
    always #12.5 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Unexpected result gets a note that can never match
    always @(negedge clk) begin
        if (done === 1'h1 || fail === 1'h1) begin
            nt = (notes.size() > 0) ? notes.pop_front() : 17'h000FF;
            `CHK("result", nt[8:0], {fail, last_data & nt[16:9]})
        end
    end
    task automatic run(input logic poll, input logic [1:0] k, input logic [7:0] n,
                       input logic to, input logic ab);
        int i;
        seed = xs(seed);
        kind = k;
        n_reads = n;
        to_flag = to;
        mode_poll = poll;
        status_addr = seed[ADDR_W-1:0];
        expect_data = (k == 2'h2) ? 8'hFF : seed[31:24];
        load = 1'h1;
        repeat (4) @(posedge clk);
        #1;
        `CHK("ready_pin", n == 8'h00, device_ready)
        load = 1'h0;
        start = 1'h1;
        if (!ab) notes.push_back(to ? 17'h04120 : {8'hFF, 1'h0, expect_data});
        @(posedge clk);
        #1;
        start = 1'h0;
        if (ab) begin
            repeat (30) @(posedge clk);
            #1;
            abort = 1'h1;
        end
        for (i = 0; i < 3000 && busy !== 1'h0; i++) @(posedge clk);
        #1;
        abort = 1'h0;
        `CHK("idle", 1'h0, busy)
        if (to) begin
            repeat (4) @(posedge clk);
            #1;
            `CHK("ready_back", 1'h1, device_ready)
        end
    endtask
    initial begin
        #(25 * 40000);
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_b = 1'h1;
        run(1'h0, 2'h1, 8'h03, 1'h0, 1'h0);
        run(1'h1, 2'h1, 8'h02, 1'h0, 1'h0);
        run(1'h1, 2'h2, 8'h04, 1'h0, 1'h0);
        run(1'h0, 2'h2, 8'h02, 1'h0, 1'h0);
        run(1'h0, 2'h0, 8'h00, 1'h0, 1'h0);
        run(1'h0, 2'h1, 8'h01, 1'h1, 1'h0);
        run(1'h1, 2'h1, 8'h01, 1'h1, 1'h0);
        run(1'h1, 2'h1, 8'h64, 1'h0, 1'h1);
        repeat (4) begin
            seed = xs(seed);
            run(seed[0], {seed[1], ~seed[1]}, {5'h00, seed[4:2]}, 1'h0, 1'h0);
        end
        `CHK("pending", 0, notes.size())
        report_and_stop();
    end
endmodule // fwsr_host_bench
